// ===== logic/risr_consts.svh
`ifndef RISR_CONSTS_SVH
`define RISR_CONSTS_SVH

// Register indices as printed; byte address is four times the index
`define RISR_IDX_MAIN_MASK    8'h14
`define RISR_IDX_TF_MASK      8'h15
`define RISR_IDX_EW_MASK      8'h16
`define RISR_IDX_MAIN_STATUS  8'h17
`define RISR_IDX_TF_STATUS    8'h18
`define RISR_IDX_EW_STATUS    8'h19

// Reset values
`define RISR_RST_MASK         8'h00
`define RISR_RST_STATUS       8'h00

// Main status field positions
`define RISR_MAIN_OSC         7
`define RISR_MAIN_FIFO_LEVEL  6
`define RISR_MAIN_RX_START    5
`define RISR_MAIN_RX_END      4
`define RISR_MAIN_TX_END      3
`define RISR_MAIN_COLLISION   2
`define RISR_MAIN_TF_SUM      1
`define RISR_MAIN_EW_SUM      0

// Bits of main status cleared by its own read
`define RISR_MAIN_RC_MASK     8'hfc
// Main mask bits that exist; summary positions are unused
`define RISR_MAIN_MASK_BITS   8'hfc

`endif

// ===== logic/risr_pkg.sv
package risr_pkg;

  // Raw one-cycle event pulses from the front end
  typedef struct packed {
    logic       osc_stable;
    logic       fifo_rx_almost_full;
    logic       fifo_tx_almost_empty;
    logic       rx_start;
    logic       rx_end;
    logic       tx_end;
    logic       bit_collision;
    logic [7:0] timer_field;
    logic       crc_err;
    logic       parity_err;
    logic       soft_framing_flag;
    logic       hard_framing_flag;
    logic       wakeup_timeout_flag;
    logic       amplitude_delta;
    logic       phase_delta;
    logic       capacitance_delta;
  } risr_events_t;

  // Context lines qualifying some events
  typedef struct packed {
    logic receiving;
    logic transmitting;
    logic wakeup_irq_each;
  } risr_ctx_t;

endpackage : risr_pkg

// ===== logic/risr_sticky_reg.sv
`timescale 1ns/1ns
// One 8-bit sticky status register with read-to-clear
module risr_sticky_reg #(
  parameter int        WIDTH    = 8,
  parameter logic [7:0] CLR_MASK = 8'hff
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             soft_clear,
  input  wire logic             read_clear,
  input  wire logic [WIDTH-1:0] set_bits,
  // State
  output      logic [WIDTH-1:0] status_q
);

  logic [WIDTH-1:0] status_d;

  always_comb
  begin
    status_d = status_q;
    if (read_clear)
    begin
      status_d = status_q & ~CLR_MASK[WIDTH-1:0];
    end
    // Set after clear so a simultaneous event survives
    status_d = status_d | set_bits;
    if (soft_clear)
    begin
      status_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= '0;
    end
    else
    begin
      status_q <= status_d;
    end
  end

endmodule : risr_sticky_reg

// ===== logic/risr_irq_block.sv
`timescale 1ns/1ns
`include "risr_consts.svh"
// Behaviour
// - Mask register 0x16 bits: CRC, parity, soft, hard framing, wake timer, amp, phase, cap.
// - Error/wake-up mask reads zero after reset and set-default.
// - Main bit 7 sets when enabled oscillator becomes stable.
// - Main bit 6 sets at FIFO almost-full during reception.
// - Main bit 6 sets at FIFO almost-empty during transmission.
// - Main bits 5..2: receive start, receive end, transmit end, collision.
// - Main bit 1 summarises pending timer/field events.
// - Main bit 0 summarises pending error/wake-up events.
// - All status registers clear at reset and set-default.
// - Reading main status returns value, then clears bits 7..2.
// - Summary bits clear only with their detail register: its read, reset or set-default.
// - Timer/field bits 7..5: command end, no-response, general timer.
// - Timer/field bit 4 field on, bit 3 field off.
// - Timer/field bit 2: external field during collision avoidance.
// - Timer/field bit 1: own field on after guard time.
// - Timer/field bit 0: target recognised initiator bit rate.
// - Reading timer/field status returns value then clears it.
// - Error bits 7..5: CRC, parity, soft framing.
// - Error bit 4: hard framing error.
// - Error bit 3: wake-up timeout when every-timeout option chosen.
// - Reading error/wake-up status returns value then clears it.
// - Mask registers 0x14 and 0x15 for main and timer sources, reset zero.
module risr_irq_block #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output      logic [31:0]            prdata,
  output      logic                   pready,
  output      logic                   pslverr,
  // Event sources
  input  wire risr_pkg::risr_events_t events,
  input  wire risr_pkg::risr_ctx_t    ctx,
  input  wire logic                   osc_enable,
  input  wire logic                   set_default_cmd,
  // Interrupt request
  output      logic                   irq
);

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic [ADDR_W-1:0] word_idx;
  logic              access;
  logic              wr_en;
  logic              rd_en;
  logic              hit_main_mask;
  logic              hit_tf_mask;
  logic              hit_ew_mask;
  logic              hit_main_st;
  logic              hit_tf_st;
  logic              hit_ew_st;
  logic              hit_any;

  assign word_idx = {2'b00, paddr[ADDR_W-1:2]};
  assign access   = psel & penable;
  assign wr_en    = access & pwrite;
  assign rd_en    = access & ~pwrite;
  assign pready   = 1'b1;

  always_comb
  begin
    hit_main_mask = 1'b0;
    hit_tf_mask   = 1'b0;
    hit_ew_mask   = 1'b0;
    hit_main_st   = 1'b0;
    hit_tf_st     = 1'b0;
    hit_ew_st     = 1'b0;
    if (paddr[1:0] != 2'b00)
    begin
      hit_any = 1'b0;
    end
    else if (word_idx == ADDR_W'(`RISR_IDX_MAIN_MASK))
    begin
      hit_main_mask = 1'b1;
    end
    else if (word_idx == ADDR_W'(`RISR_IDX_TF_MASK))
    begin
      hit_tf_mask = 1'b1;
    end
    else if (word_idx == ADDR_W'(`RISR_IDX_EW_MASK))
    begin
      hit_ew_mask = 1'b1;
    end
    else if (word_idx == ADDR_W'(`RISR_IDX_MAIN_STATUS))
    begin
      hit_main_st = 1'b1;
    end
    else if (word_idx == ADDR_W'(`RISR_IDX_TF_STATUS))
    begin
      hit_tf_st = 1'b1;
    end
    else if (word_idx == ADDR_W'(`RISR_IDX_EW_STATUS))
    begin
      hit_ew_st = 1'b1;
    end
    hit_any = hit_main_mask | hit_tf_mask | hit_ew_mask
            | hit_main_st | hit_tf_st | hit_ew_st;
  end

  // Writes to status registers are refused as well as unmapped addresses
  assign pslverr = access & (~hit_any | (pwrite & (hit_main_st | hit_tf_st | hit_ew_st)));

  // ==========================================================
  // Mask registers
  // ==========================================================
  logic [7:0] main_irq_mask_q;
  logic [7:0] timer_field_irq_mask_q;
  logic [7:0] error_wakeup_irq_mask_q;
  logic       mask_wr_ok;

  assign mask_wr_ok = wr_en & pstrb[0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_irq_mask_q <= `RISR_RST_MASK;
    end
    else if (set_default_cmd)
    begin
      main_irq_mask_q <= `RISR_RST_MASK;
    end
    else if (mask_wr_ok && hit_main_mask)
    begin
      main_irq_mask_q <= pwdata[7:0] & `RISR_MAIN_MASK_BITS;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_field_irq_mask_q <= `RISR_RST_MASK;
    end
    else if (set_default_cmd)
    begin
      timer_field_irq_mask_q <= `RISR_RST_MASK;
    end
    else if (mask_wr_ok && hit_tf_mask)
    begin
      timer_field_irq_mask_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      error_wakeup_irq_mask_q <= `RISR_RST_MASK;
    end
    else if (set_default_cmd)
    begin
      error_wakeup_irq_mask_q <= `RISR_RST_MASK;
    end
    else if (mask_wr_ok && hit_ew_mask)
    begin
      error_wakeup_irq_mask_q <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Event capture
  // ==========================================================
  // Oscillator flag only meaningful once software has enabled it
  logic       osc_stable_ev;
  logic [7:0] main_set;
  logic [7:0] tf_set;
  logic [7:0] ew_set;
  logic [7:0] main_status_q;
  logic [7:0] tf_status_q;
  logic [7:0] ew_status_q;
  logic       fifo_level_flag;

  assign osc_stable_ev = events.osc_stable & osc_enable;
  assign fifo_level_flag = (events.fifo_rx_almost_full & ctx.receiving)
                         | (events.fifo_tx_almost_empty & ctx.transmitting);

  always_comb
  begin
    main_set = 8'h00;
    main_set[`RISR_MAIN_OSC]        = osc_stable_ev;
    main_set[`RISR_MAIN_FIFO_LEVEL] = fifo_level_flag;
    main_set[`RISR_MAIN_RX_START]   = events.rx_start;
    main_set[`RISR_MAIN_RX_END]     = events.rx_end;
    main_set[`RISR_MAIN_TX_END]     = events.tx_end;
    main_set[`RISR_MAIN_COLLISION]  = events.bit_collision;
  end

  // Bit 7 command end .. bit 0 bit-rate recognised, in register order
  assign tf_set = events.timer_field;

  assign ew_set = {events.crc_err,
                   events.parity_err,
                   events.soft_framing_flag,
                   events.hard_framing_flag,
                   events.wakeup_timeout_flag & ctx.wakeup_irq_each,
                   events.amplitude_delta,
                   events.phase_delta,
                   events.capacitance_delta};

  // ==========================================================
  // Read-clear guard
  // ==========================================================
  // An event landing at the setup edge is missing from prdata, so the clear keeps it
  logic [7:0] main_keep;
  logic [7:0] tf_keep;
  logic [7:0] ew_keep;

  always_comb
  begin
    main_keep = 8'h00;
    tf_keep   = 8'h00;
    ew_keep   = 8'h00;
    if (rd_en && hit_main_st)
    begin
      main_keep = main_status_q & ~prdata[7:0];
    end
    if (rd_en && hit_tf_st)
    begin
      tf_keep = tf_status_q & ~prdata[7:0];
    end
    if (rd_en && hit_ew_st)
    begin
      ew_keep = ew_status_q & ~prdata[7:0];
    end
  end

  // ==========================================================
  // Status registers
  // ==========================================================
  // Read-clear happens at the access edge, after the value was returned
  risr_sticky_reg #(
    .WIDTH    (8),
    .CLR_MASK (`RISR_MAIN_RC_MASK)
  ) u_main_status (
    .pclk       (pclk),
    .presetn    (presetn),
    .soft_clear (set_default_cmd),
    .read_clear (rd_en & hit_main_st),
    .set_bits   (main_set | main_keep),
    .status_q   (main_status_q)
  );

  risr_sticky_reg #(
    .WIDTH    (8),
    .CLR_MASK (8'hff)
  ) u_tf_status (
    .pclk       (pclk),
    .presetn    (presetn),
    .soft_clear (set_default_cmd),
    .read_clear (rd_en & hit_tf_st),
    .set_bits   (tf_set | tf_keep),
    .status_q   (tf_status_q)
  );

  risr_sticky_reg #(
    .WIDTH    (8),
    .CLR_MASK (8'hff)
  ) u_ew_status (
    .pclk       (pclk),
    .presetn    (presetn),
    .soft_clear (set_default_cmd),
    .read_clear (rd_en & hit_ew_st),
    .set_bits   (ew_set | ew_keep),
    .status_q   (ew_status_q)
  );

  // Summary bits follow detail registers, so they clear only when those are read, reset or set to default
  logic [7:0] main_view;

  always_comb
  begin
    main_view = main_status_q & `RISR_MAIN_RC_MASK;
    main_view[`RISR_MAIN_TF_SUM] = |tf_status_q;
    main_view[`RISR_MAIN_EW_SUM] = |ew_status_q;
  end

  // ==========================================================
  // Read data and interrupt
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      if (hit_main_mask)
      begin
        prdata <= {24'h00_0000, main_irq_mask_q};
      end
      else if (hit_tf_mask)
      begin
        prdata <= {24'h00_0000, timer_field_irq_mask_q};
      end
      else if (hit_ew_mask)
      begin
        prdata <= {24'h00_0000, error_wakeup_irq_mask_q};
      end
      else if (hit_main_st)
      begin
        prdata <= {24'h00_0000, main_view};
      end
      else if (hit_tf_st)
      begin
        prdata <= {24'h00_0000, tf_status_q};
      end
      else if (hit_ew_st)
      begin
        prdata <= {24'h00_0000, ew_status_q};
      end
      else
      begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Registered so the pin is glitch free toward the host
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(main_status_q & ~main_irq_mask_q & `RISR_MAIN_RC_MASK)
           | |(tf_status_q & ~timer_field_irq_mask_q)
           | |(ew_status_q & ~error_wakeup_irq_mask_q);
    end
  end

endmodule : risr_irq_block

// ===== dv/risr_host_model.sv
`timescale 1ns/1ns
// ==========
// Host controller model: plain APB master
module risr_host_model (
  // Clock
  input  wire logic        pclk,
  // APB master side
  output      logic        psel,
  output      logic        penable,
  output      logic        pwrite,
  output      logic [7:0]  paddr,
  output      logic [31:0] pwdata,
  output      logic [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;

  // Call just after a rising edge; an idle cycle follows, so no re-drive clash
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
endmodule : risr_host_model

// ===== dv/risr_irq_sva.sv
`timescale 1ns/1ns
module risr_irq_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [ADDR_W-1:0]      paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire risr_pkg::risr_events_t events,
  input wire logic                   set_default_cmd,
  input wire logic                   irq
);
  logic acc, bad, st;
  assign acc = psel && penable;
  assign bad = paddr[1:0] != 2'b00 || paddr[7:2] < 6'h14 || paddr[7:2] > 6'h19;
  assign st = paddr[7:2] >= 6'h17;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Bus answers
  ready_now_a: assert property (acc |-> pready) else $error("no ready");
  err_code_a: assert property (acc |-> pslverr == (bad || (pwrite && st)))
    else $error("bad error flag");
  err_zero_a: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
    else $error("unmapped data");
  hi_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper data");
  mmask_low_a: assert property (acc && !pwrite && paddr == 8'h50 |-> prdata[1:0] == 2'b00)
    else $error("mask low bits");
  // ==========
  // Interrupt line
  irq_rise_a: assert property ($rose(irq) |-> $past(events != '0, 2) || $past(acc && pwrite, 2))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(acc || set_default_cmd, 2))
    else $error("irq fell without clear");
  sdef_irq_a: assert property (set_default_cmd |-> ##2 !irq)
    else $error("irq after default");
  cover property ($rose(irq));
  cover property (acc && pslverr);
  cover property (set_default_cmd);
endmodule : risr_irq_sva

// ===== dv/tb_risr_irq_block.sv
`timescale 1ns/1ns
module tb_risr_irq_block;
  logic                   pclk, presetn, osc_en, sdef, irq, e;
  logic                   psel, penable, pwrite, pready, pslverr;
  logic [7:0]             paddr, mm, mt, me, sm, st, se, x;
  logic [31:0]            pwdata, prdata, r;
  logic [3:0]             pstrb;
  risr_pkg::risr_events_t ev;
  risr_pkg::risr_ctx_t    cx;
  int                     n_mismatch, cmp_count;

  risr_irq_block risr_irq_block_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .events(ev), .ctx(cx),
    .osc_enable(osc_en), .set_default_cmd(sdef), .irq);
  risr_host_model risr_host_model_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr);

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task wrap_up;
    $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] s, input logic [31:0] w);
    cmp_count++;
    if (s !== w)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, s, w);
    end
  endtask : chk

  // ==========
  // Reference model: sticky bits, summaries derived live
  function logic [7:0] mv(input logic [7:0] i);
    case (i)
      8'h14: return mm;
      8'h15: return mt;
      8'h16: return me;
      8'h17: return {sm[7:2], |st, |se};
      8'h18: return st;
      8'h19: return se;
      default: return 8'h00;
    endcase
  endfunction : mv

  task rd(input logic [7:0] i);
    risr_host_model_inst.xfer(1'b0, {i[5:0], 2'b00}, 32'h0, r, e);
    chk(r, {24'h0, mv(i)});
    chk({31'h0, e}, {31'h0, i < 8'h14 || i > 8'h19});
    if (i == 8'h17) sm = '0;
    if (i == 8'h18) st = '0;
    if (i == 8'h19) se = '0;
  endtask : rd

  task wr(input logic [7:0] i, input logic [7:0] d);
    risr_host_model_inst.xfer(1'b1, {i[5:0], 2'b00}, {24'h0, d}, r, e);
    chk({31'h0, e}, {31'h0, i > 8'h16});
  endtask : wr

  task upd(input risr_pkg::risr_events_t v, input risr_pkg::risr_ctx_t c, input logic o);
    sm |= {v.osc_stable & o, (v.fifo_rx_almost_full & c.receiving)
      | (v.fifo_tx_almost_empty & c.transmitting), v.rx_start, v.rx_end, v.tx_end,
      v.bit_collision, 2'b00};
    st |= v.timer_field;
    se |= {v.crc_err, v.parity_err, v.soft_framing_flag, v.hard_framing_flag,
      v.wakeup_timeout_flag & c.wakeup_irq_each, v.amplitude_delta, v.phase_delta,
      v.capacitance_delta};
  endtask : upd

  task fire;
    risr_pkg::risr_events_t v;
    risr_pkg::risr_ctx_t    c;
    logic                   o;
    v = 23'($urandom & $urandom);
    c = 3'($urandom);
    o = 1'($urandom);
    ev <= v;
    cx <= c;
    osc_en <= o;
    @(posedge pclk);
    ev <= '0;
    upd(v, c, o);
    @(posedge pclk);
  endtask : fire

  task ckirq;
    logic a;
    a = |(sm & ~mm) | |(st & ~mt) | |(se & ~me);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, a});
    @(posedge pclk);
  endtask : ckirq

  initial
  begin
    repeat (6000) @(posedge pclk);
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    {ev, cx, osc_en, sdef, presetn} = '0;
    {sm, st, se, mm, mt, me} = '0;
    void'($urandom(76036));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 8'h14; i <= 8'h1a; i++) rd(8'(i));
    wr(8'h17, 8'hff);
    repeat (40)
    begin
      {mm, mt, me} = 24'($urandom);
      wr(8'h14, mm);
      wr(8'h15, mt);
      wr(8'h16, me);
      mm &= 8'hfc;
      rd(8'h14);
      rd(8'h16);
      repeat ($urandom_range(1, 3)) fire();
      ckirq();
      rd(8'(8'h17 + $urandom_range(0, 2)));
    end
    fire();
    x = st;
    fork
      risr_host_model_inst.xfer(1'b0, 8'h60, 32'h0, r, e);
      begin
        @(posedge pclk);
        ev.timer_field <= 8'ha5;
        @(posedge pclk);
        ev <= '0;
      end
    join
    chk(r, {24'h0, x});
    st = 8'ha5;
    // Event at the setup edge is not in the returned value and must survive
    x = st;
    fork
      risr_host_model_inst.xfer(1'b0, 8'h60, 32'h0, r, e);
      begin
        ev.timer_field <= 8'h5a;
        @(posedge pclk);
        ev <= '0;
      end
    join
    chk(r, {24'h0, x});
    st = 8'h5a;
    rd(8'h17);
    rd(8'h18);
    fire();
    sdef <= 1'b1;
    @(posedge pclk);
    sdef <= 1'b0;
    {sm, st, se, mm, mt, me} = '0;
    @(posedge pclk);
    for (int i = 8'h14; i <= 8'h19; i++) rd(8'(i));
    wrap_up();
  end
endmodule : tb_risr_irq_block

bind risr_irq_block risr_irq_sva #(.ADDR_W(ADDR_W)) risr_irq_sva_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .events,
  .set_default_cmd, .irq);
